// file: pkg/fps_pkg.sv
// Constants and types of the floating-point status flag block
package fps_pkg;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int STAT_W = 32;
    localparam int POS_SHADOW = 31;
    localparam int POS_RND_DBL = 10;
    localparam int POS_RND_SGL = 9;
    localparam int POS_TEST = 6;
    localparam int POS_INT_ZERO = 5;
    localparam int POS_INT_NEG = 4;
    localparam int POS_FP_ZERO = 3;
    localparam int POS_FP_NEG = 2;
    localparam int POS_LAT_UNF = 1;
    localparam int POS_LAT_EXC = 0;
    localparam int RSV_HI_W = 20;
    localparam int RSV_LO_W = 2;
    localparam int FLG_W = 7;
    localparam logic [STAT_W-1:0] STAT_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Main status register select bits (zero, negative, excess, test, carry)
    // ------------------------------------------------------------
    localparam int SEL_W = 5;
    localparam int SEL_Z = 0;
    localparam int SEL_N = 1;
    localparam int SEL_EXC = 2;
    localparam int SEL_TEST = 3;
    localparam int SEL_C = 4;

    // ------------------------------------------------------------
    // Floating-point operand fields
    // ------------------------------------------------------------
    localparam int VAL_W = 64;
    localparam int SGL_SIGN = 31;
    localparam int SGL_EXP_HI = 30;
    localparam int SGL_EXP_LO = 23;
    localparam int DBL_SIGN = 63;
    localparam int DBL_EXP_HI = 62;
    localparam int DBL_EXP_LO = 52;
    localparam int INT_W = 32;

    typedef struct packed {
        logic shadow;
        logic roundDbl;
        logic roundSgl;
        logic testFlag;
        logic intZero;
        logic intNeg;
        logic fpZero;
        logic fpNeg;
        logic latUnf;
        logic latExc;
    } fps_stat_type;

    typedef struct packed {
        fps_stat_type stat;
        logic mainWr;
        logic [SEL_W-1:0] mainMask;
        logic [SEL_W-1:0] mainVal;
    } fps_state_type;

endpackage

// file: pkg/fps_link_if.sv
// Interface between the status core and its classify and transfer units
`timescale 1ns/1ps
`default_nettype none
interface fps_link_if
    import fps_pkg::*;
();
    logic [VAL_W-1:0] value;
    logic isDouble;
    logic fpZero;
    logic fpNeg;
    logic intZero;
    logic intNeg;
    logic [SEL_W-1:0] sel;
    fps_stat_type cur;
    logic [SEL_W-1:0] mainVal;
    logic clrExc;
    logic clrUnf;

    modport clsCore (output value, output isDouble, input fpZero, input fpNeg,
                     input intZero, input intNeg);
    modport clsUnit (input value, input isDouble, output fpZero, output fpNeg,
                     output intZero, output intNeg);
    modport xfrCore (output sel, output cur, input mainVal, input clrExc, input clrUnf);
    modport xfrUnit (input sel, input cur, output mainVal, output clrExc, output clrUnf);
endinterface
`default_nettype wire

// file: rtl/fps_classify.sv
// Zero and negative classification of a moved value
`timescale 1ns/1ps
`default_nettype none
module fps_classify
    import fps_pkg::*;
(
    fps_link_if.clsUnit lnk
);
    logic [DBL_EXP_HI-DBL_EXP_LO:0] dblExp;
    logic [SGL_EXP_HI-SGL_EXP_LO:0] sglExp;
    logic expZero;
    logic sign;

    always_comb begin
        dblExp = lnk.value[DBL_EXP_HI:DBL_EXP_LO];
        sglExp = lnk.value[SGL_EXP_HI:SGL_EXP_LO];
        // A zero exponent covers both signed zeros and denormals: all read as +0
        expZero = lnk.isDouble ? (dblExp == '0) : (sglExp == '0);
        sign = lnk.isDouble ? lnk.value[DBL_SIGN] : lnk.value[SGL_SIGN];
        lnk.fpZero = expZero;
        lnk.fpNeg = sign & ~expZero;
        lnk.intZero = (lnk.value[INT_W-1:0] == '0);
        lnk.intNeg = lnk.value[INT_W-1];
    end
endmodule
`default_nettype wire

// file: rtl/fps_transfer.sv
// Mapping of selected status flags onto the main status register bits
`timescale 1ns/1ps
`default_nettype none
module fps_transfer
    import fps_pkg::*;
(
    fps_link_if.xfrUnit lnk
);
    always_comb begin
        lnk.mainVal = '0;
        lnk.mainVal[SEL_Z] = lnk.cur.fpZero;
        lnk.mainVal[SEL_N] = lnk.cur.fpNeg;
        lnk.mainVal[SEL_EXC] = lnk.cur.latExc;
        lnk.mainVal[SEL_TEST] = lnk.cur.testFlag;
        lnk.mainVal[SEL_C] = lnk.cur.latUnf;
        lnk.clrExc = lnk.sel[SEL_EXC];
        lnk.clrUnf = lnk.sel[SEL_C];
    end
endmodule
`default_nettype wire

// file: rtl/fps_status_flags.sv
// Floating-point status register with flag update, transfer and rounding modes
//
// Function
// - Moves into a floating-point register update zero and negative flags from the value.
// - Compare, min, max, negate and absolute results update zero and negative flags.
// - Arithmetic overflow or underflow sets the latched excess and underflow flags.
// - Latched excess and underflow flags are driven out as interrupt event levels.
// - Flag transfer copies each selected flag into its main status register bit.
// - Flag transfer clears latched excess or underflow when that flag is selected.
// - Restore forces the shadow-mode bit 31 to zero.
// - Save sets the shadow-mode bit to one.
// - Status load from memory leaves the shadow-mode bit unchanged; restore from shadow clears it.
// - Bits 30 to 11 and 8 to 7 are reserved and read zero.
// - Bit 10 picks double rounding: zero truncates, one rounds to nearest even.
// - Bit 9 picks single rounding: zero truncates, one rounds to nearest even.
// - Condition test writes test flag bit 6, clearing it when the condition is false.
// - Set-flags and save may also modify the test flag.
// - Every status field clears to zero at reset.
// - Latched underflow sits at bit 1, latched excess at bit 0.
// - Condition test sets the test flag when the condition is true.
// - Integer zero bit 5 and negative bit 4 follow the moved integer value.
// - Negative zero and denormals count as positive zero for the flags.
`timescale 1ns/1ps
`default_nettype none
module fps_status_flags
    import fps_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    // Value written to a floating-point register
    input wire logic wrValid,
    input wire logic wrDouble,
    input wire logic wrInt,
    input wire logic [VAL_W-1:0] wrValue,
    // Compare outcome
    input wire logic cmpValid,
    input wire logic cmpZero,
    input wire logic cmpNeg,
    // Arithmetic exceptions
    input wire logic arithValid,
    input wire logic arithOvf,
    input wire logic arithUnf,
    // Condition test
    input wire logic testValid,
    input wire logic testCond,
    // Set-flags and save share one mask and value over bits 6..0
    input wire logic setFlagsValid,
    input wire logic saveValid,
    input wire logic [FLG_W-1:0] flgMask,
    input wire logic [FLG_W-1:0] flgValue,
    // Status load from memory or restore from shadow copy
    input wire logic ldValid,
    input wire logic [STAT_W-1:0] ldValue,
    input wire logic restoreValid,
    input wire logic [STAT_W-1:0] restoreValue,
    // Flag transfer to main status register
    input wire logic xferValid,
    input wire logic [SEL_W-1:0] xferSel,
    output logic mainWr,
    output logic [SEL_W-1:0] mainMask,
    output logic [SEL_W-1:0] mainVal,
    // Status read and mode outputs
    output logic [STAT_W-1:0] statusOut,
    output logic roundDouble,
    output logic roundSingle,
    output logic excessEvent,
    output logic underflowEvent
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fps_state_type cur_ff;
    fps_state_type nxt_cur;
    logic [STAT_W-1:0] srcWord;

    fps_link_if lnk ();

    fps_classify u_classify (
        .lnk(lnk.clsUnit)
    );

    fps_transfer u_transfer (
        .lnk(lnk.xfrUnit)
    );

    assign lnk.value = wrValue;
    assign lnk.isDouble = wrDouble;
    assign lnk.sel = xferSel;
    assign lnk.cur = cur_ff.stat;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // One instruction per cycle is expected; where several strobes meet,
    // later steps override earlier ones and exception sets come last.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.mainWr = 1'b0;
        srcWord = restoreValid ? restoreValue : ldValue;
        if (ldValid || restoreValid) begin
            nxt_cur.stat.roundDbl = srcWord[POS_RND_DBL];
            nxt_cur.stat.roundSgl = srcWord[POS_RND_SGL];
            nxt_cur.stat[FLG_W-1:0] = srcWord[FLG_W-1:0];
        end
        if (restoreValid) begin
            nxt_cur.stat.shadow = 1'b0;
        end
        if (setFlagsValid || saveValid) begin
            // Only masked flags change; covers test flag too
            nxt_cur.stat[FLG_W-1:0] = (nxt_cur.stat[FLG_W-1:0] & ~flgMask)
                | (flgValue & flgMask);
        end
        if (saveValid) begin
            nxt_cur.stat.shadow = 1'b1;
        end
        if (testValid) begin
            nxt_cur.stat.testFlag = testCond;
        end
        if (wrValid) begin
            nxt_cur.stat.fpZero = lnk.fpZero;
            nxt_cur.stat.fpNeg = lnk.fpNeg;
            if (wrInt) begin
                nxt_cur.stat.intZero = lnk.intZero;
                nxt_cur.stat.intNeg = lnk.intNeg;
            end
        end
        if (cmpValid) begin
            nxt_cur.stat.fpZero = cmpZero;
            nxt_cur.stat.fpNeg = cmpNeg & ~cmpZero;
        end
        if (xferValid) begin
            nxt_cur.mainWr = 1'b1;
            nxt_cur.mainMask = xferSel;
            nxt_cur.mainVal = lnk.mainVal & xferSel;
            if (lnk.clrExc) begin
                nxt_cur.stat.latExc = 1'b0;
            end
            if (lnk.clrUnf) begin
                nxt_cur.stat.latUnf = 1'b0;
            end
        end
        // Sticky set wins over any clear in the same cycle
        if (arithValid) begin
            nxt_cur.stat.latExc = nxt_cur.stat.latExc | arithOvf;
            nxt_cur.stat.latUnf = nxt_cur.stat.latUnf | arithUnf;
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign statusOut = {cur_ff.stat.shadow, {RSV_HI_W{1'b0}}, cur_ff.stat.roundDbl,
        cur_ff.stat.roundSgl, {RSV_LO_W{1'b0}}, cur_ff.stat[FLG_W-1:0]};
    // Rounding selects feed the datapaths directly
    assign roundDouble = cur_ff.stat.roundDbl;
    assign roundSingle = cur_ff.stat.roundSgl;
    assign excessEvent = cur_ff.stat.latExc;
    assign underflowEvent = cur_ff.stat.latUnf;
    assign mainWr = cur_ff.mainWr;
    assign mainMask = cur_ff.mainMask;
    assign mainVal = cur_ff.mainVal;

endmodule
`default_nettype wire

// file: test/fps_cpu_model.sv
// Behavioural model of the main status register fed by flag transfers
`timescale 1ns/1ps
`default_nettype none
module fps_cpu_model
    import fps_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic mainWr,
    input wire logic [SEL_W-1:0] mainMask,
    input wire logic [SEL_W-1:0] mainVal,
    output logic [SEL_W-1:0] mainBits
);
    // Only selected bits move; the rest keep what branches last saw
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mainBits <= 5'h00;
        end else if (mainWr) begin
            mainBits <= (mainBits & ~mainMask) | (mainVal & mainMask);
        end
    end
endmodule
`default_nettype wire

// file: test/fps_status_flags_props.sv
// Assertions on the status flag block ports
`timescale 1ns/1ps
`default_nettype none
module fps_status_flags_props
    import fps_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic arithValid,
    input wire logic arithOvf,
    input wire logic setFlagsValid,
    input wire logic saveValid,
    input wire logic ldValid,
    input wire logic restoreValid,
    input wire logic xferValid,
    input wire logic [SEL_W-1:0] xferSel,
    input wire logic mainWr,
    input wire logic [SEL_W-1:0] mainMask,
    input wire logic [STAT_W-1:0] statusOut,
    input wire logic excessEvent
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_RSV: assert property (statusOut[30:11] == 20'h0 && statusOut[8:7] == 2'h0)
        else $error("reserved bits not zero");
    AST_XFR: assert property (xferValid |=> mainWr && mainMask == $past(xferSel))
        else $error("transfer write wrong");
    AST_CLR: assert property (xferValid && xferSel[SEL_EXC] && !arithValid |=> !statusOut[0])
        else $error("latched excess not cleared");
    AST_SET: assert property (arithValid && arithOvf |=> statusOut[0] && excessEvent)
        else $error("excess not latched");
    AST_STICKY: assert property (statusOut[0] && !setFlagsValid && !saveValid && !ldValid
        && !restoreValid && !(xferValid && xferSel[SEL_EXC]) |=> statusOut[0])
        else $error("latched excess dropped");
    AST_SAVE: assert property (saveValid |=> statusOut[31])
        else $error("save left shadow clear");
    AST_RESTORE: assert property (restoreValid && !saveValid |=> !statusOut[31])
        else $error("restore left shadow set");
    AST_LOAD: assert property (ldValid && !restoreValid && !saveValid |=> $stable(statusOut[31]))
        else $error("load changed shadow");
    cover property (xferValid && xferSel[SEL_EXC] && statusOut[0]);
    cover property (saveValid ##[1:40] restoreValid);
    cover property (ldValid);
endmodule
`default_nettype wire
bind fps_status_flags fps_status_flags_props fps_status_flags_props_inst (.clock, .rst_b,
    .arithValid, .arithOvf, .setFlagsValid, .saveValid, .ldValid, .restoreValid, .xferValid,
    .xferSel, .mainWr, .mainMask, .statusOut, .excessEvent);

// file: test/tb_top.sv
// Self-checking bench of the status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fps_pkg::*;
;
    logic clock = 0;
    logic rst_b = 0;
    logic [8:0] strb = '0;
    logic [6:0] misc = '0;
    logic [6:0] mask = '0;
    logic [63:0] val = '0;
    logic mainWr, roundDouble, roundSingle, excessEvent, underflowEvent;
    logic [SEL_W-1:0] mainMask, mainVal, mainBits;
    logic [STAT_W-1:0] statusOut;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [63:0] wrVals [4] = '{64'h8000_0000, 64'h1, 64'hbf80_0000, 64'hc000_0000_0000_0000};
    logic [6:0] wrMisc [4] = '{7'h20, 7'h20, 7'h20, 7'h60};
    logic [3:0] wrExp [4] = '{4'h6, 4'h2, 4'h5, 4'h9};

    fps_status_flags fps_status_flags_inst (.clock(clock), .rst_b(rst_b), .wrValid(strb[0]),
        .wrDouble(misc[6]), .wrInt(misc[5]), .wrValue(val), .cmpValid(strb[1]),
        .cmpZero(misc[4]), .cmpNeg(misc[3]), .arithValid(strb[2]), .arithOvf(misc[2]),
        .arithUnf(misc[1]), .testValid(strb[3]), .testCond(misc[0]), .setFlagsValid(strb[4]),
        .saveValid(strb[5]), .flgMask(mask), .flgValue(val[6:0]), .ldValid(strb[6]),
        .ldValue(val[31:0]), .restoreValid(strb[7]), .restoreValue(val[31:0]),
        .xferValid(strb[8]), .xferSel(mask[4:0]), .mainWr(mainWr), .mainMask(mainMask),
        .mainVal(mainVal), .statusOut(statusOut), .roundDouble(roundDouble),
        .roundSingle(roundSingle), .excessEvent(excessEvent), .underflowEvent(underflowEvent));
    fps_cpu_model fps_cpu_model_inst (.clock(clock), .rst_b(rst_b), .mainWr(mainWr),
        .mainMask(mainMask), .mainVal(mainVal), .mainBits(mainBits));

    initial begin
        forever #12.5 clock = ~clock;
    end

    // One instruction strobe for one cycle, then settle past the taking edge
    task automatic fire(input logic [8:0] s, input logic [6:0] m, input logic [6:0] k,
                        input logic [63:0] v);
        @(posedge clock);
        strb <= s;
        misc <= m;
        mask <= k;
        val <= v;
        @(posedge clock);
        strb <= 9'h000;
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk("reset", 32'h0, statusOut);
        fire(9'h004, 7'h04, 7'h00, 64'h0);
        chk("ovf", 32'h1, statusOut);
        chk("ovfEvt", 32'h1, {31'h0, excessEvent});
        fire(9'h004, 7'h02, 7'h00, 64'h0);
        chk("unf", 32'h3, statusOut);
        repeat (3) @(posedge clock);
        #1;
        chk("sticky", 32'h3, {statusOut[31:2], underflowEvent, excessEvent});
        fire(9'h100, 7'h00, 7'h04, 64'h0);
        chk("xferWr", 32'h1, {31'h0, mainWr});
        chk("xferMask", 32'h4, {27'h0, mainMask});
        chk("xferVal", 32'h4, {27'h0, mainVal});
        chk("ovfClr", 32'h2, statusOut);
        @(posedge clock);
        #1;
        chk("mainWr", 32'h0, {31'h0, mainWr});
        fire(9'h100, 7'h00, 7'h10, 64'h0);
        chk("unfXfer", 32'h10, {27'h0, mainVal});
        chk("unfClr", 32'h0, statusOut);
        // The partner takes the write one edge after the pulse appears
        @(posedge clock);
        #1;
        chk("mainBits", 32'h14, {27'h0, mainBits});
        for (int i = 0; i < 4; i++) begin
            fire(9'h001, wrMisc[i], 7'h00, wrVals[i]);
            chk("moveFlags", {28'h0, wrExp[i]}, {28'h0, statusOut[5:2]});
        end
        fire(9'h100, 7'h00, 7'h03, 64'h0);
        chk("znXfer", 32'h2, {27'h0, mainVal});
        // Without the integer qualifier the integer flags must hold
        fire(9'h001, 7'h00, 7'h00, 64'h8000_0000);
        chk("moveNoInt", 32'ha, {28'h0, statusOut[5:2]});
        fire(9'h002, 7'h08, 7'h00, 64'h0);
        chk("cmpNeg", 32'h1, {30'h0, statusOut[3:2]});
        fire(9'h002, 7'h18, 7'h00, 64'h0);
        chk("cmp", 32'h2, {30'h0, statusOut[3:2]});
        fire(9'h008, 7'h01, 7'h00, 64'h0);
        chk("testTrue", 32'h1, {31'h0, statusOut[6]});
        fire(9'h100, 7'h00, 7'h08, 64'h0);
        chk("tcXfer", 32'h8, {27'h0, mainVal});
        fire(9'h008, 7'h00, 7'h00, 64'h0);
        chk("testFalse", 32'h0, {31'h0, statusOut[6]});
        fire(9'h010, 7'h00, 7'h7f, 64'h40);
        chk("set_flags_insn", 32'h40, statusOut);
        fire(9'h020, 7'h00, 7'h00, 64'h0);
        chk("save", 32'h8000_0040, statusOut);
        fire(9'h040, 7'h00, 7'h00, 64'hffff_ffff);
        chk("load", 32'h8000_067f, statusOut);
        chk("rounding", 32'h3, {30'h0, roundDouble, roundSingle});
        fire(9'h080, 7'h00, 7'h00, 64'h0);
        chk("restore", 32'h0, statusOut);
        give_verdict();
    end
endmodule
`default_nettype wire
